// [design/umw_multiply_w_by_file.sv]
// Datapath executing the multiply-working-register-by-file instruction
`timescale 1ns/1ps
module umw_multiply_w_by_file
  import umw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic extendedEnable,
  input wire logic [3:0] bankSelect,
  input wire logic [7:0] indexBase,
  input wire logic [7:0] workingReg,
  output logic [11:0] fileAddr,
  output logic fileRead,
  input wire logic [7:0] fileData,
  output logic [7:0] productHigh,
  output logic [7:0] productLow,
  output logic productWrite,
  output logic busy
);

  // ************************************************************
  // Reset release
  // ************************************************************
  // Reset is applied at once but lifted two edges later, so no flop
  // leaves reset on an edge that races the release of the pin.
  logic nrstMeta_reg;
  logic nrstSync_reg;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nrstMeta_reg <= 1'h0;
      nrstSync_reg <= 1'h0;
    end
    else
    begin
      nrstMeta_reg <= 1'h1;
      nrstSync_reg <= nrstMeta_reg;
    end
  end

  // ************************************************************
  // Decode and address resolution
  // ************************************************************
  // True when the word carries this instruction's opcode
  function automatic logic opcodeMatch(input logic [15:0] word);
    return word[UMW_OP_MSB:UMW_OP_LSB] == UMW_OPCODE;
  endfunction

  // Quick-access bank: low addresses land in the bottom bank, the rest in
  // the top bank, so both ends stay reachable without the bank select.
  function automatic logic [11:0] quickAddr(input logic [7:0] f);
    logic [3:0] bank;
    bank = (f < UMW_ACCESS_SPLIT) ? UMW_BANK_LOW : UMW_BANK_HIGH;
    return {bank, f};
  endfunction

  // Indexed mode: the literal offset is added to the index base
  function automatic logic [11:0] indexedAddr(input logic [7:0] base, input logic [7:0] f);
    return 12'(base) + 12'(f);
  endfunction

  // Selector high always uses the bank select; indexing needs selector low
  function automatic logic [11:0] resolveAddr(input logic sel,
                                              input logic [7:0] f,
                                              input logic ext,
                                              input logic [3:0] bank,
                                              input logic [7:0] base);
    logic [11:0] a;
    if (sel)
      a = {bank, f};
    else if (ext && f <= UMW_INDEX_LIMIT)
      a = indexedAddr(base, f);
    else
      a = quickAddr(f);
    return a;
  endfunction

  logic isMul;
  logic selBit;
  logic [7:0] fileField;
  logic [11:0] resolvedAddr;
  assign selBit = instrWord[UMW_SEL_BIT];
  assign fileField = instrWord[UMW_ADDR_MSB:UMW_ADDR_LSB];
  assign isMul = instrValid && opcodeMatch(instrWord);
  assign resolvedAddr = resolveAddr(selBit, fileField, extendedEnable, bankSelect, indexBase);

  // ************************************************************
  // Phase sequencer
  // ************************************************************
  umw_phase_t phase_reg;
  umw_phase_t phase_next;
  logic active_reg;
  logic active_next;
  logic takeInstr;

  // Words offered while busy are dropped without a sign: there is no queue,
  // the fetch side must hold its word until the sequencer is back in Q1.
  assign takeInstr = (phase_reg == UMW_Q1) && !active_reg && isMul;

  always_comb
  begin
    phase_next = phase_reg;
    active_next = active_reg;
    unique case (phase_reg)
      UMW_Q1:
      begin
        if (takeInstr)
        begin
          phase_next = UMW_Q2;
          active_next = 1'h1;
        end
      end
      UMW_Q2: phase_next = UMW_Q3;
      UMW_Q3: phase_next = UMW_Q4;
      UMW_Q4:
      begin
        phase_next = UMW_Q1;
        active_next = 1'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      phase_reg <= UMW_Q1;
    else
      phase_reg <= phase_next;
  end

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      active_reg <= 1'h0;
    else
      active_reg <= active_next;
  end

  // ************************************************************
  // Operand capture
  // ************************************************************
  logic [11:0] addr_reg;
  logic [7:0] wCopy_reg;
  logic [7:0] fCopy_reg;

  // Address and working register are latched at the take, so the fetch
  // side may move on while the instruction runs.
  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      addr_reg <= UMW_ADDR_RESET;
    else if (takeInstr)
      addr_reg <= resolvedAddr;
  end

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      wCopy_reg <= UMW_BYTE_RESET;
    else if (takeInstr)
      wCopy_reg <= workingReg;
  end

  // Read-only copy of the file byte, taken at the end of Q2
  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      fCopy_reg <= UMW_BYTE_RESET;
    else if (phase_reg == UMW_Q2)
      fCopy_reg <= fileData;
  end

  // ************************************************************
  // Compute
  // ************************************************************
  function automatic logic [15:0] mulBytes(input logic [7:0] a, input logic [7:0] b);
    return 16'(a) * 16'(b);
  endfunction

  logic [15:0] product_reg;
  logic [15:0] product_next;
  assign product_next = mulBytes(wCopy_reg, fCopy_reg);

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      product_reg <= UMW_PROD_RESET;
    else if (phase_reg == UMW_Q3)
      product_reg <= product_next;
  end

  // ************************************************************
  // Product pair write
  // ************************************************************
  // Only the pair is written: there are no flag outputs, so a zero or
  // full-scale product leaves the status word as it was.
  logic productWrite_next;
  assign productWrite_next = phase_reg == UMW_Q4;

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      productWrite <= 1'h0;
    else
      productWrite <= productWrite_next;
  end

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      productHigh <= UMW_BYTE_RESET;
    else if (productWrite_next)
      productHigh <= product_reg[UMW_PROD_HI_MSB:UMW_PROD_HI_LSB];
  end

  always_ff @(posedge ref_clk or negedge nrstSync_reg)
  begin
    if (!nrstSync_reg)
      productLow <= UMW_BYTE_RESET;
    else if (productWrite_next)
      productLow <= product_reg[UMW_PROD_LO_MSB:UMW_PROD_LO_LSB];
  end

  assign fileAddr = addr_reg;
  assign fileRead = phase_reg == UMW_Q2;
  assign busy = active_reg;
endmodule // umw_multiply_w_by_file

// [design/umw_pkg.sv]
// Constants and types for the multiply-working-register-by-file datapath
package umw_pkg;
  localparam logic [6:0] UMW_OPCODE = 7'h01;
  localparam int UMW_OP_MSB = 15;
  localparam int UMW_OP_LSB = 9;
  localparam int UMW_SEL_BIT = 8;
  localparam int UMW_ADDR_MSB = 7;
  localparam int UMW_ADDR_LSB = 0;
  localparam int UMW_PROD_HI_MSB = 15;
  localparam int UMW_PROD_HI_LSB = 8;
  localparam int UMW_PROD_LO_MSB = 7;
  localparam int UMW_PROD_LO_LSB = 0;
  localparam logic [11:0] UMW_ADDR_RESET = 12'h000;
  localparam logic [15:0] UMW_PROD_RESET = 16'h0000;
  localparam logic [7:0] UMW_INDEX_LIMIT = 8'h5F;
  // Quick-access bank: offsets below 0x60 map to bank 0, the rest to the top bank
  localparam logic [7:0] UMW_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] UMW_BANK_LOW = 4'h0;
  localparam logic [3:0] UMW_BANK_HIGH = 4'hF;
  localparam logic [7:0] UMW_BYTE_RESET = 8'h00;
  typedef enum logic [1:0] {UMW_Q1, UMW_Q2, UMW_Q3, UMW_Q4} umw_phase_t;
endpackage

// [sim/umw_multiply_w_by_file_assertions.sv]
// Port checker for the multiply datapath
`timescale 1ns/1ps
module umw_multiply_w_by_file_assertions
  import umw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic instrValid,
  input wire logic extendedEnable,
  input wire logic fileRead,
  input wire logic productWrite,
  input wire logic busy,
  input wire logic [15:0] instrWord,
  input wire logic [3:0] bankSelect,
  input wire logic [7:0] indexBase,
  input wire logic [7:0] workingReg,
  input wire logic [7:0] fileData,
  input wire logic [7:0] productHigh,
  input wire logic [7:0] productLow,
  input wire logic [11:0] fileAddr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_run; busy [*3] ##1 !busy && productWrite; endsequence
  property p_run; fileRead |-> s_run; endproperty
  a_run: assert property (p_run) else $error("busy or write timing");
  property p_rd; fileRead |=> !fileRead; endproperty
  a_rd: assert property (p_rd) else $error("read not one cycle");
  property p_val; logic [7:0] w, d;
    (fileRead, w = $past(workingReg), d = fileData) |->
    ##3 {productHigh, productLow} == 16'(w) * 16'(d); endproperty
  a_val: assert property (p_val) else $error("bad product");
  property p_hold; !productWrite |-> $stable({productHigh, productLow}); endproperty
  a_hold: assert property (p_hold) else $error("product moved");
  property p_dec; fileRead |-> $past(instrValid) && $past(instrWord[15:9]) == UMW_OPCODE;
  endproperty
  a_dec: assert property (p_dec) else $error("bad decode");
  property p_bank; fileRead && $past(instrWord[8]) |->
    fileAddr == {$past(bankSelect), $past(instrWord[7:0])}; endproperty
  a_bank: assert property (p_bank) else $error("bad banked address");
  property p_quick; fileRead && !$past(instrWord[8]) && !($past(extendedEnable) &&
    $past(instrWord[7:0]) <= UMW_INDEX_LIMIT) |-> fileAddr == {($past(instrWord[7:0]) >=
    UMW_ACCESS_SPLIT ? UMW_BANK_HIGH : UMW_BANK_LOW), $past(instrWord[7:0])}; endproperty
  a_quick: assert property (p_quick) else $error("bad quick address");
  property p_idx; fileRead && !$past(instrWord[8]) && $past(extendedEnable) &&
    $past(instrWord[7:0]) <= UMW_INDEX_LIMIT |->
    fileAddr == 12'($past(indexBase)) + 12'($past(instrWord[7:0])); endproperty
  a_idx: assert property (p_idx) else $error("bad indexed address");
endmodule // umw_multiply_w_by_file_assertions
bind umw_multiply_w_by_file umw_multiply_w_by_file_assertions u_chk (.*);

// [sim/umw_multiply_w_by_file_test.sv]
// Self-checking bench for the multiply datapath
`timescale 1ns/1ps
module umw_multiply_w_by_file_test;
  logic ref_clk = 0, nrst = 0, instrValid = 0, extendedEnable = 0;
  logic fileRead, productWrite, busy;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0] bankSelect = 4'hA;
  logic [7:0] indexBase = 8'hF0, workingReg = 8'h00, fileData = 8'h00, productHigh, productLow;
  logic [11:0] fileAddr;
  int n_fail = 0, cmp_count = 0;
  umw_multiply_w_by_file uut (.*);
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Issue one word; ok=0 means the word must be ignored
  task automatic mul(input logic [15:0] iw, input logic ext, input logic [7:0] w, d,
                     input logic [11:0] ea, input logic ok);
    int i;
    instrWord = iw;
    extendedEnable = ext;
    workingReg = w;
    instrValid = 1;
    for (i = 0; i < 9 && fileRead !== 1'b1; i++) @(negedge ref_clk);
    instrValid = 0;
    chk(fileRead, ok);
    chk(busy, ok);
    if (fileRead !== ok) finish_test;
    if (ok)
    begin
      fileData = d;
      chk(fileAddr, ea);
      repeat (3) @(negedge ref_clk);
      fileData = ~d;
      chk(busy, 0);
      chk(productWrite, 1);
      chk({productHigh, productLow}, 16'(w) * 16'(d));
    end
  endtask
  task automatic sc_banked;
    mul(16'h0334, 1, 8'hE2, 8'hB5, 12'hA34, 1);
  endtask
  task automatic sc_quick;
    mul(16'h0270, 0, 8'hFF, 8'hFF, 12'hF70, 1);
    mul(16'h0220, 0, 8'h07, 8'h09, 12'h020, 1);
  endtask
  task automatic sc_indexed;
    mul(16'h025F, 1, 8'h10, 8'h0F, 12'h14F, 1);
    mul(16'h0260, 1, 8'h00, 8'h33, 12'hF60, 1);
  endtask
  // A matching word held while busy must not start a second run
  task automatic sc_busy;
    int i;
    instrWord = 16'h0312;
    workingReg = 8'h03;
    instrValid = 1;
    for (i = 0; i < 9 && fileRead !== 1'b1; i++) @(negedge ref_clk);
    chk(fileRead, 1);
    if (fileRead !== 1'b1) finish_test;
    fileData = 8'h05;
    instrWord = 16'h0345;
    workingReg = 8'hFF;
    @(negedge ref_clk);
    chk(fileRead, 0);
    chk(fileAddr, 12'hA12);
    @(negedge ref_clk);
    instrValid = 0;
    chk(busy, 1);
    @(negedge ref_clk);
    chk(productWrite, 1);
    chk({productHigh, productLow}, 16'h000F);
  endtask
  // Matching word without valid, then a valid word of another opcode
  task automatic sc_refused;
    instrWord = 16'h0334;
    repeat (2) @(negedge ref_clk);
    chk(fileRead, 0);
    chk(busy, 0);
    mul(16'h0434, 0, 8'h11, 8'h22, 12'h000, 0);
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    nrst = 1;
    repeat (3) @(negedge ref_clk);
    sc_banked;
    sc_quick;
    sc_indexed;
    sc_busy;
    sc_refused;
    finish_test;
  end
endmodule // umw_multiply_w_by_file_test
